// ===== hw/helium_level_consts.svh
// Timing counts and field constants for the helium level sequencer.
`ifndef HELIUM_LEVEL_CONSTS_SVH
`define HELIUM_LEVEL_CONSTS_SVH
`define CLK_HZ            125000000
`define CLK_NS            8
`define PROT_OFF_S        6
`define PROT_OFF_CYC      (`PROT_OFF_S * `CLK_HZ)
`define SEC_DIV_CYC       `CLK_HZ
`define BOOST_MS          100
`define BOOST_CYC         (`BOOST_MS * (`CLK_HZ / 1000))
`define CUR_4K_MA         8'h4B
`define CUR_2K_MA         8'h39
`define BOOST_EXTRA_MA    8'h0A
`define BURN_MARGIN_RST   8'h32
`endif

// ===== hw/helium_level_pkg.sv
// Types shared by the helium level sequencer.
package helium_level_pkg;
  typedef enum logic [1:0] {st_idle, st_energ, st_prot} sens_st_t;
  typedef struct packed {
    logic        src_nitrogen;
    logic        at_or_above;
    logic [15:0] setpoint;
  } trip_cfg_t;
  typedef struct packed {
    sens_st_t    st;
    logic        continuous_mode;
    logic [31:0] sec_cnt;
    logic [31:0] run_sec;
    logic [31:0] samp_sec;
    logic [31:0] prot_cnt;
    logic [31:0] boost_cnt;
    logic        boost;
    logic [15:0] held_volt;
    logic [15:0] he_level;
    logic        he_level_vld;
    logic [1:0]  alarm;
    logic [1:0]  relay;
    logic        mute;
  } state_t;
endpackage

// ===== hw/helium_level_seq.sv
// Helium level sensor sequencer with level alarms and relays.
// Functional notes
// RL1: Continuous mode energizes sensor and times out back to sampled mode.
// RL2: Continuous limit zero means no timeout.
// RL3: Sampled mode energizes sensor once per sample period.
// RL4: Sample timer restarts at reset, period write and sampled entry.
// RL5: Sample period zero keeps the sensor energized always.
// RL6: Burnout margin sets tolerated excess resistance; typical about five percent.
// RL7: Excess resistance flags protection, current off six seconds, then retry.
// RL8: Protection ends once resistance is back in range.
// RL9: Protection never changes alarm or relay outputs.
// RL10: Each toggle request flips sampled and continuous modes.
// RL11: Voltage is live in continuous mode, held and stale otherwise.
// RL12: Measure request energizes sensor and updates level, voltage, current; the code captures only level and held voltage, with no current reading.
// RL13: Current target is 75 mA for 4K sensors, 57 mA for 2K.
// RL14: Boost raises current briefly at cycle start, sampled mode only.
// RL15: Two level alarms with source choice and above or below setpoint.
// RL16: Any active alarm drives audible and visual outputs.
// RL17: Mute silences audible until an alarm changes state.
// RL18: Two normally-open relays with own setpoints, independent of alarms.
// RL19: Relay source and comparison direction are configurable.
// RL20: Combined alarm status vector is always readable.
// RL21: Comparisons update on a new reading and hold between readings.
// RL22: Operator exit from continuous mode de-energizes and clears run timer.
`timescale 1ns/100ps
`default_nettype none
`include "helium_level_consts.svh"
module helium_level_seq
  import helium_level_pkg::*;
#(
  parameter int unsigned PROT_OFF_CYCLES = `PROT_OFF_CYC,
  parameter int unsigned SEC_CYCLES      = `SEC_DIV_CYC,
  parameter int unsigned BOOST_CYCLES    = `BOOST_CYC
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Operator controls.
  input  wire logic        mode_toggle_req,
  input  wire logic        measure_req,
  input  wire logic        alarm_mute_request,
  // Configuration.
  input  wire logic        sensor_is_2k,
  input  wire logic        boost_enable,
  input  wire logic [31:0] sample_period_s,
  input  wire logic        sample_period_wr,
  input  wire logic [31:0] continuous_run_limit,
  input  wire logic [7:0]  burnout_margin_pct,
  input  wire trip_cfg_t   alarm_cfg_0,
  input  wire trip_cfg_t   alarm_cfg_1,
  input  wire trip_cfg_t   relay_cfg_0,
  input  wire trip_cfg_t   relay_cfg_1,
  // Sensor measurement front end.
  input  wire logic [15:0] sensor_volt,
  input  wire logic [15:0] sensor_res,
  input  wire logic [15:0] sensor_res_expected,
  input  wire logic [15:0] helium_level_in,
  input  wire logic [15:0] nitrogen_level,
  input  wire logic        nitrogen_level_vld,
  // Sensor drive and status.
  output logic             sensor_energize,
  output logic [7:0]       current_target_ma,
  output logic             continuous_mode,
  output logic             protection_active,
  output logic [15:0]      reported_volt,
  output logic             volt_stale,
  output logic [15:0]      liquid_helium_channel,
  output logic             helium_level_vld,
  // Alarms and relays.
  output logic [1:0]       alarm_status,
  output logic             audible_alert,
  output logic             visual_alarm,
  output logic [1:0]       relay_close
);

  state_t s_r;
  state_t s_nxt;
  trip_cfg_t acfg [2];
  trip_cfg_t rcfg [2];
  logic        excess;
  logic [25:0] res_lim;
  logic        sec_tick;
  logic [1:0]  alarm_eval;
  logic [1:0]  relay_eval;

  assign acfg[0] = alarm_cfg_0;
  assign acfg[1] = alarm_cfg_1;
  assign rcfg[0] = relay_cfg_0;
  assign rcfg[1] = relay_cfg_1;

  // Limit is expected resistance times (100 + margin) / 100, scaled by 100.
  // RL6 margin threshold
  // 26 bits hold the largest resistance at the largest margin without wrapping.
  assign res_lim = 26'(sensor_res_expected) * (26'(burnout_margin_pct) + 26'h64);
  assign excess  = (26'(sensor_res) * 26'h64) > res_lim;
  assign sec_tick = (s_r.sec_cnt == SEC_CYCLES - 1);

  // Per-channel comparison; a trip only moves when its source has a new reading.
  // RL15 RL19 compare
  for (genvar i = 0; i < 2; i++) begin : g_trip
    logic [15:0] alvl;
    logic [15:0] rlvl;
    assign alvl = acfg[i].src_nitrogen ? nitrogen_level : s_r.he_level;
    assign rlvl = rcfg[i].src_nitrogen ? nitrogen_level : s_r.he_level;
    assign alarm_eval[i] = acfg[i].at_or_above ? (alvl >= acfg[i].setpoint)
                                               : (alvl <= acfg[i].setpoint);
    assign relay_eval[i] = rcfg[i].at_or_above ? (rlvl >= rcfg[i].setpoint)
                                               : (rlvl <= rcfg[i].setpoint);
  end

  // Next-state logic for the whole sequencer.
  always_comb begin
    logic samp_due;
    logic start_meas;
    samp_due   = 1'b0;
    start_meas = 1'b0;
    s_nxt = s_r;
    s_nxt.he_level_vld = 1'b0;
    // Timer restarts clear this prescaler too, except a period write in continuous mode, so a first sampled period is never cut short.
    s_nxt.sec_cnt = sec_tick ? 32'h0 : s_r.sec_cnt + 32'h1;
    // RL10 mode toggle
    if (mode_toggle_req) begin
      s_nxt.continuous_mode = ~s_r.continuous_mode;
      s_nxt.run_sec = 32'h0;
      // RL4 restart on sampled entry
      s_nxt.samp_sec = 32'h0;
      s_nxt.sec_cnt = 32'h0;
    end else if (s_r.continuous_mode && sec_tick && s_r.st != st_prot) begin
      s_nxt.run_sec = s_r.run_sec + 32'h1;
      // RL1 RL2 run limit
      if (continuous_run_limit != 32'h0 && s_r.run_sec + 32'h1 >= continuous_run_limit) begin
        s_nxt.continuous_mode = 1'b0;
        s_nxt.run_sec = 32'h0;
        s_nxt.samp_sec = 32'h0;
        s_nxt.sec_cnt = 32'h0;
      end
    end
    // RL3 RL4 interval timer
    if (sample_period_wr) begin
      s_nxt.samp_sec = 32'h0;
      if (!s_nxt.continuous_mode) s_nxt.sec_cnt = 32'h0;
    end else if (!s_r.continuous_mode && !mode_toggle_req && sec_tick
                 && sample_period_s != 32'h0) begin
      if (s_r.samp_sec + 32'h1 >= sample_period_s) begin
        s_nxt.samp_sec = 32'h0;
        samp_due = 1'b1;
      end else begin
        s_nxt.samp_sec = s_r.samp_sec + 32'h1;
      end
    end
    start_meas = samp_due || measure_req;
    case (s_r.st)
      st_idle: begin
        // RL1 RL5 RL12 energize
        if (s_nxt.continuous_mode || sample_period_s == 32'h0 || start_meas) begin
          s_nxt.st = st_energ;
          // RL14 boost in sampled mode
          s_nxt.boost = boost_enable && !s_nxt.continuous_mode;
          s_nxt.boost_cnt = 32'h0;
        end
      end
      st_energ: begin
        if (s_r.boost) begin
          s_nxt.boost_cnt = s_r.boost_cnt + 32'h1;
          if (s_r.boost_cnt >= BOOST_CYCLES - 1) s_nxt.boost = 1'b0;
        end
        // RL14 no boost when continuous
        if (s_nxt.continuous_mode) s_nxt.boost = 1'b0;
        // RL7 burnout trip
        if (excess) begin
          s_nxt.st = st_prot;
          s_nxt.prot_cnt = 32'h0;
          s_nxt.boost = 1'b0;
        end else if (!s_r.boost) begin
          // Reading is taken once boost has ended.
          s_nxt.he_level = helium_level_in;
          s_nxt.held_volt = sensor_volt;
          s_nxt.he_level_vld = 1'b1;
          // RL22 exit de-energizes
          if (!s_nxt.continuous_mode && sample_period_s != 32'h0) s_nxt.st = st_idle;
        end
      end
      st_prot: begin
        // RL7 RL8 off time then retry
        if (s_r.prot_cnt >= PROT_OFF_CYCLES - 1) begin
          s_nxt.st = st_energ;
        end else begin
          s_nxt.prot_cnt = s_r.prot_cnt + 32'h1;
        end
      end
      default: s_nxt.st = st_idle;
    endcase
    // RL21 RL9 evaluate on new readings only
    for (int i = 0; i < 2; i++) begin
      if ((acfg[i].src_nitrogen && nitrogen_level_vld) ||
          (!acfg[i].src_nitrogen && s_r.he_level_vld)) s_nxt.alarm[i] = alarm_eval[i];
      // RL18 independent relays
      if ((rcfg[i].src_nitrogen && nitrogen_level_vld) ||
          (!rcfg[i].src_nitrogen && s_r.he_level_vld)) s_nxt.relay[i] = relay_eval[i];
    end
    // RL17 mute with change clearing it
    if (s_nxt.alarm != s_r.alarm) begin
      s_nxt.mute = 1'b0;
    end else if (alarm_mute_request && s_r.alarm != 2'h0) begin
      s_nxt.mute = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come from state, except that reported_volt and current_target_ma also use live inputs.
  assign sensor_energize       = (s_r.st == st_energ);
  // RL13 RL14 current target
  assign current_target_ma     = (sensor_is_2k ? `CUR_2K_MA : `CUR_4K_MA)
                                 + (s_r.boost ? `BOOST_EXTRA_MA : 8'h00);
  assign continuous_mode       = s_r.continuous_mode;
  assign protection_active     = (s_r.st == st_prot);
  // RL11 live or held voltage
  assign reported_volt         = s_r.continuous_mode ? sensor_volt : s_r.held_volt;
  assign volt_stale            = !s_r.continuous_mode;
  assign liquid_helium_channel = s_r.he_level;
  assign helium_level_vld      = s_r.he_level_vld;
  // RL20 status vector
  assign alarm_status          = s_r.alarm;
  // RL16 alert outputs
  assign visual_alarm          = |s_r.alarm;
  assign audible_alert         = |s_r.alarm && !s_r.mute;
  assign relay_close           = s_r.relay;

  property p_toggle;
    @(posedge mclk) disable iff (!rst_b)
      mode_toggle_req |=> continuous_mode != $past(continuous_mode);
  endproperty
  a_toggle: assert property (p_toggle) else $error("mode did not toggle"); // RL10

  property p_prot_hold;
    @(posedge mclk) disable iff (!rst_b)
      $rose(protection_active) |-> !sensor_energize [*8];
  endproperty
  a_prot_hold: assert property (p_prot_hold) else $error("sensor energized in protection"); // RL7

  property p_prot_entry;
    @(posedge mclk) disable iff (!rst_b)
      sensor_energize && excess |=> protection_active;
  endproperty
  a_prot_entry: assert property (p_prot_entry) else $error("burnout not caught"); // RL7

  property p_prot_alarm;
    @(posedge mclk) disable iff (!rst_b)
      $changed(protection_active) && !$past(s_r.he_level_vld) && !$past(nitrogen_level_vld)
        |-> $stable(alarm_status) && $stable(relay_close);
  endproperty
  a_prot_alarm: assert property (p_prot_alarm) else $error("protection moved outputs"); // RL9

  property p_cont_energ;
    @(posedge mclk) disable iff (!rst_b)
      $rose(continuous_mode) && !excess && !protection_active |-> ##[1:2] sensor_energize;
  endproperty
  a_cont_energ: assert property (p_cont_energ) else $error("continuous not energized"); // RL1

  property p_exit;
    @(posedge mclk) disable iff (!rst_b)
      continuous_mode && mode_toggle_req && sample_period_s != 32'h0 && sensor_energize
        |=> !sensor_energize;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not de-energize"); // RL22

  property p_volt;
    @(posedge mclk) disable iff (!rst_b)
      volt_stale == !continuous_mode && (continuous_mode -> reported_volt == sensor_volt);
  endproperty
  a_volt: assert property (p_volt) else $error("voltage source wrong"); // RL11

  property p_mute;
    @(posedge mclk) disable iff (!rst_b)
      $changed(alarm_status) |-> audible_alert == (alarm_status != 2'h0);
  endproperty
  a_mute: assert property (p_mute) else $error("mute not cleared on change"); // RL17

  property p_alert;
    @(posedge mclk) disable iff (!rst_b)
      visual_alarm == (alarm_status != 2'h0) && (audible_alert -> visual_alarm);
  endproperty
  a_alert: assert property (p_alert) else $error("alert outputs wrong"); // RL16

  property p_boost;
    @(posedge mclk) disable iff (!rst_b)
      continuous_mode |-> current_target_ma == (sensor_is_2k ? `CUR_2K_MA : `CUR_4K_MA);
  endproperty
  a_boost: assert property (p_boost) else $error("boost outside sampled mode"); // RL14

  // Alarms and relays hold when neither channel produced a reading.
  property p_level_hold;
    @(posedge mclk) disable iff (!rst_b)
      !$past(s_r.he_level_vld) && !$past(nitrogen_level_vld)
        |-> $stable(alarm_status) && $stable(relay_close);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("trip moved unread"); // RL21

  // A zero limit never ends continuous mode on its own.
  property p_no_limit;
    @(posedge mclk) disable iff (!rst_b)
      continuous_mode && continuous_run_limit == 32'h0 && !mode_toggle_req |=> continuous_mode;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("zero limit timed out"); // RL2

  // A zero period keeps the sensor powered unless burnout steps in.
  property p_always_on;
    @(posedge mclk) disable iff (!rst_b)
      sample_period_s == 32'h0 && sensor_energize && !excess |=> sensor_energize;
  endproperty
  a_always_on: assert property (p_always_on) else $error("zero period dropped power"); // RL5

  // A sampled energization lasts one reading, which limits helium boil-off.
  property p_sampled_one;
    @(posedge mclk) disable iff (!rst_b)
      sensor_energize && !continuous_mode && sample_period_s != 32'h0 && !excess
        && !s_r.boost && !mode_toggle_req |=> !sensor_energize;
  endproperty
  a_sampled_one: assert property (p_sampled_one) else $error("sampled power held on"); // RL3

  // Each energized cycle past the boost without excess resistance captures the front-end level.
  property p_read;
    @(posedge mclk) disable iff (!rst_b)
      sensor_energize && !excess && !s_r.boost
        |=> helium_level_vld && liquid_helium_channel == $past(helium_level_in);
  endproperty
  a_read: assert property (p_read) else $error("reading not captured"); // RL12

  // Without boost the target is the nominal current of the sensor type.
  property p_current;
    @(posedge mclk) disable iff (!rst_b)
      !s_r.boost |-> current_target_ma == (sensor_is_2k ? 8'h39 : 8'h4B);
  endproperty
  a_current: assert property (p_current) else $error("nominal current wrong"); // RL13

  // A mute request silences the alert unless an alarm moves at the same time.
  property p_mute_set;
    @(posedge mclk) disable iff (!rst_b)
      alarm_mute_request && alarm_status != 2'h0 |=> !audible_alert || $changed(alarm_status);
  endproperty
  a_mute_set: assert property (p_mute_set) else $error("mute not applied"); // RL17

  // Leaving continuous mode by hand clears the run timer.
  property p_exit_timer;
    @(posedge mclk) disable iff (!rst_b)
      continuous_mode && mode_toggle_req |=> s_r.run_sec == 32'h0;
  endproperty
  a_exit_timer: assert property (p_exit_timer) else $error("run timer not cleared"); // RL22

endmodule // helium_level_seq
`default_nettype wire

// ===== verif/helium_sensor_model.sv
// Behavioural helium level sensor that feeds the sequencer front end.
`timescale 1ns/100ps
`default_nettype none
module helium_sensor_model (
  // Clock and sensor drive.
  input  wire logic        mclk,
  input  wire logic        energize,
  // Bench controls: true level and an overheated filament.
  input  wire logic [15:0] true_level,
  input  wire logic        overheat,
  // Front-end readings.
  output logic [15:0]      volt,
  output logic [15:0]      res,
  output logic [15:0]      res_exp,
  output logic [15:0]      level
);
  logic [15:0] junk_r = 16'h5A5A;
  // An unpowered filament gives no reading, so the lines churn every cycle.
  always_ff @(posedge mclk) begin
    junk_r <= ~junk_r ^ true_level;
  end
  // Readings mean something only while current flows.
  always_comb begin
    res_exp = 16'h0400;
    res     = !energize ? junk_r : (overheat ? 16'h0800 : 16'h0400);
    volt    = energize ? 16'h1E00 - true_level : junk_r;
    level   = energize ? true_level : junk_r;
  end
endmodule // helium_sensor_model
`default_nettype wire

// ===== verif/test_helium_level_seq.sv
// Self-checking bench for the helium level sequencer.
`timescale 1ns/100ps
`default_nettype none
module test_helium_level_seq;
  import helium_level_pkg::*;
  logic mclk = 0, rst_b = 0, tog = 0, meas = 0, mute = 0, is_2k = 0, boost = 0, wr = 0;
  logic burn = 0, n2_vld = 0, en, cont, prot, stale, vld, aud, vis;
  logic [31:0] period = 32'h0000FFFF, limit = 32'h0, n;
  logic [15:0] he = 16'h0050, n2 = 16'h0200, sv, sr, se, sl, rv, ch;
  logic [7:0] margin = 8'h05, cur;
  logic [1:0] alm, rly;
  trip_cfg_t a0 = '{1'b0, 1'b1, 16'h0040}, a1 = '{1'b0, 1'b0, 16'h0010};
  trip_cfg_t r0 = '{1'b0, 1'b0, 16'h0060}, r1 = '{1'b1, 1'b1, 16'h0100};
  int fail_count = 0, tests_run = 0;
  // Short counts keep the six-second lockout and the second tick cheap.
  helium_level_seq #(.PROT_OFF_CYCLES(20), .SEC_CYCLES(10), .BOOST_CYCLES(4)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .mode_toggle_req(tog), .measure_req(meas),
    .alarm_mute_request(mute), .sensor_is_2k(is_2k), .boost_enable(boost),
    .sample_period_s(period), .sample_period_wr(wr), .continuous_run_limit(limit),
    .burnout_margin_pct(margin), .alarm_cfg_0(a0), .alarm_cfg_1(a1), .relay_cfg_0(r0),
    .relay_cfg_1(r1), .sensor_volt(sv), .sensor_res(sr), .sensor_res_expected(se),
    .helium_level_in(sl), .nitrogen_level(n2), .nitrogen_level_vld(n2_vld),
    .sensor_energize(en), .current_target_ma(cur), .continuous_mode(cont),
    .protection_active(prot), .reported_volt(rv), .volt_stale(stale),
    .liquid_helium_channel(ch), .helium_level_vld(vld), .alarm_status(alm),
    .audible_alert(aud), .visual_alarm(vis), .relay_close(rly));
  helium_sensor_model model_u (.mclk(mclk), .energize(en), .true_level(he),
    .overheat(burn), .volt(sv), .res(sr), .res_exp(se), .level(sl));
  // Free-running clock, 8 ns period.
  always #4 mclk = ~mclk;
  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk) #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A wait that runs out ends the run at once.
  task automatic reached(input string what, input logic ok);
    check(what, ok, 1'b1);
    if (ok !== 1'b1) complete_run;
  endtask
  // One requested reading, checked for a valid level, then two cycles for the alarm outputs to settle.
  task automatic measure_once;
    meas = 1; tick; meas = 0;
    for (n = 0; n < 6 && vld !== 1'b1; n++) tick;
    reached("reading", vld);
    check("level", ch, he);
    tick(2);
  endtask
  task automatic sc_alarms_relays;
    n2_vld = 1; tick; n2_vld = 0;
    measure_once;
    check("alarms", alm, 2'b01);
    check("relays", rly, 2'b11);
    check("audible", {aud, vis}, 2'b11);
    mute = 1; tick; mute = 0; tick(2);
    check("muted", {aud, vis}, 2'b01);
    he = 16'h0008; tick(3);
    check("held", alm, 2'b01);
    measure_once;
    check("alarms2", alm, 2'b10);
    check("rearmed", aud, 1'b1);
    check("relay held", rly, 2'b11);
  endtask
  task automatic sc_burnout;
    burn = 1; meas = 1; tick; meas = 0;
    for (n = 0; n < 6 && prot !== 1'b1; n++) tick;
    reached("protect", prot);
    for (n = 0; n < 19; n++) begin
      check("off", en, 1'b0);
      tick;
    end
    check("alarms kept", {alm, rly}, 4'b1011);
    burn = 0;
    for (n = 0; n < 80 && prot !== 1'b0; n++) tick;
    reached("recovered", !prot);
    check("alarms kept2", {alm, rly}, 4'b1011);
  endtask
  task automatic sc_interval;
    period = 32'h3; wr = 1; tick; wr = 0;
    for (n = 0; n < 60 && en !== 1'b1; n++) tick;
    reached("sampled", en);
    check("interval", n >= 25 && n <= 35, 1'b1);
    period = 32'h0; wr = 1; tick; wr = 0; tick(40);
    check("always on", en, 1'b1);
    period = 32'h0000FFFF; wr = 1; tick; wr = 0; tick(3);
  endtask
  task automatic sc_continuous;
    limit = 32'h2; tog = 1; tick; tog = 0; tick(2);
    check("cont", {cont, en, stale}, 3'b110);
    check("live volt", rv, 16'h1E00 - he);
    for (n = 0; n < 60 && cont !== 1'b0; n++) tick;
    reached("timeout", !cont);
    check("limit", n >= 15 && n <= 25, 1'b1);
    tick(2);
    check("stale", {en, stale}, 2'b01);
    limit = 32'h0; tog = 1; tick; tog = 0; tick(60);
    check("no limit", {cont, en}, 2'b11);
    tog = 1; tick; tog = 0;
    check("exit now", en, 1'b0);
    tick(2);
    check("exit", {cont, en}, 2'b00);
  endtask
  task automatic sc_current;
    is_2k = 1; tick;
    check("2k", cur, 8'h39);
    boost = 1; meas = 1; tick; meas = 0;
    for (n = 0; n < 4 && en !== 1'b1; n++) tick;
    reached("boost start", en);
    check("boost", cur, 8'h43);
    tick(10); boost = 0; is_2k = 0; tick;
  endtask
  initial begin
    tick(8);
    check("reset", {en, cont, prot, alm, rly, aud, vis}, 9'h0);
    check("4k", cur, 8'h4B);
    rst_b = 1; tick;
    sc_alarms_relays;
    sc_burnout;
    sc_interval;
    sc_continuous;
    sc_current;
    complete_run;
  end
endmodule // test_helium_level_seq
`default_nettype wire
